// ===== inc/fti_consts.svh
// constants for the transmit symbol injection control block
`ifndef FTI_CONSTS_SVH
`define FTI_CONSTS_SVH

// register addresses on the control port
`define FTI_ADDR_TSC      5'h04
`define FTI_ADDR_THR      5'h05
`define FTI_ADDR_SYMA     5'h06
`define FTI_ADDR_SYMB     5'h07

// field positions in transmit_state_control
`define FTI_TM_LSB        0
`define FTI_TM_MSB        2
`define FTI_IC_LO_BIT     3
`define FTI_IC_HI_BIT     4
`define FTI_SMOOTH_BIT    5
`define FTI_PARITY_BIT    6
`define FTI_RSVD_BIT      7
`define FTI_IC_LO_MASK    8'h08

// reset values
`define FTI_TSC_RESET     8'ha2
`define FTI_THR_RESET     8'h00
`define FTI_SYM_RESET     5'h00
`define FTI_CNT_RESET     8'h00
`define FTI_PAIR_RESET    10'h000

// 5b line symbols
`define FTI_SYM_J         5'h18
`define FTI_SYM_K         5'h11
`define FTI_SYM_IDLE      5'h1f
`define FTI_SYM_QUIET     5'h00
`define FTI_SYM_HALT      5'h04

// timing: one symbol pair every 80 ns on a 20 ns clock
`define FTI_CLK_NS        20
`define FTI_PAIR_NS       80
`define FTI_PAIR_CYC      (`FTI_PAIR_NS / `FTI_CLK_NS)

`endif

// ===== inc/fti_pkg.sv
// types for the transmit symbol injection control block
`default_nettype none
package fti_pkg;

  typedef enum logic [1:0] {
    FTI_INJ_NONE     = 2'b00,
    FTI_INJ_ONESHOT  = 2'b01,
    FTI_INJ_PERIODIC = 2'b10,
    FTI_INJ_CONT     = 2'b11
  } fti_inj_mode_t;

  typedef enum logic [2:0] {
    FTI_TM_ACTIVE = 3'b000,
    FTI_TM_IDLE   = 3'b001,
    FTI_TM_OFF    = 3'b010,
    FTI_TM_RSV3   = 3'b011,
    FTI_TM_MASTER = 3'b100,
    FTI_TM_HALT   = 3'b101,
    FTI_TM_QUIET  = 3'b110,
    FTI_TM_RSV7   = 3'b111
  } fti_tx_mode_t;

  typedef enum logic [1:0] {
    FTI_OS_WAIT = 2'b00,
    FTI_OS_RUN  = 2'b01
  } fti_os_state_t;

endpackage
`default_nettype wire

// ===== inc/fti_cnt_if.sv
// link between the injection controller and its counter
`default_nettype none
interface fti_cnt_if;
  logic                  tick;
  logic                  jk;
  fti_pkg::fti_inj_mode_t mode;
  logic [7:0]            thr_next;
  logic                  thr_wr;
  logic                  inject;
  logic                  os_done;
  logic [7:0]            cnt;

  modport ctl (output tick, output jk, output mode, output thr_next,
               output thr_wr, input inject, input os_done, input cnt);
  modport cnt_side (input tick, input jk, input mode, input thr_next,
                    input thr_wr, output inject, output os_done,
                    output cnt);
endinterface
`default_nettype wire

// ===== rtl/fti_tx_mode_gen.sv
// symbol pair and transmitter enable for each transmit mode
`default_nettype none
`include "fti_consts.svh"
module fti_tx_mode_gen (
  input  wire fti_pkg::fti_tx_mode_t tm,
  output logic [9:0]                 pair,
  output logic                       txe
);

  // reserved codes fall back to quiet, as does off
  always_comb
  begin
    pair = {`FTI_SYM_QUIET, `FTI_SYM_QUIET};
    txe  = 1'b1;
    case (tm)
      fti_pkg::FTI_TM_IDLE:   pair = {`FTI_SYM_IDLE, `FTI_SYM_IDLE};
      fti_pkg::FTI_TM_OFF:    txe  = 1'b0;
      fti_pkg::FTI_TM_MASTER: pair = {`FTI_SYM_HALT, `FTI_SYM_QUIET};
      fti_pkg::FTI_TM_HALT:   pair = {`FTI_SYM_HALT, `FTI_SYM_HALT};
      default:                pair = {`FTI_SYM_QUIET, `FTI_SYM_QUIET};
    endcase
  end

endmodule
`default_nettype wire

// ===== rtl/fti_inj_counter.sv
// injection down-counter with one-shot arming on a starting delimiter
`default_nettype none
`include "fti_consts.svh"
module fti_inj_counter (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  fti_cnt_if.cnt_side c
);

  fti_pkg::fti_os_state_t state;
  fti_pkg::fti_os_state_t next_state;
  logic [7:0]             next_cnt;
  logic                   hit;
  logic                   periodic;
  logic                   oneshot;
  logic                   os_fire_jk;

  assign periodic   = c.mode == fti_pkg::FTI_INJ_PERIODIC;
  assign oneshot    = c.mode == fti_pkg::FTI_INJ_ONESHOT;
  // counter at one or zero means this pair is the n-th one
  assign hit        = c.cnt <= 8'h01;
  // zero threshold in one-shot replaces the delimiter pair itself
  assign os_fire_jk = oneshot && state == fti_pkg::FTI_OS_WAIT && c.jk
                      && c.thr_next == 8'h00;
  assign c.inject   = c.tick && ((periodic && hit) || os_fire_jk
                      || (oneshot && state == fti_pkg::FTI_OS_RUN
                          && hit));
  assign c.os_done  = c.inject && oneshot;

  // counting only in one-shot and periodic; delimiter starts one-shot
  always_comb
  begin
    next_cnt   = c.cnt;
    next_state = state;
    if (!oneshot)
      next_state = fti_pkg::FTI_OS_WAIT;
    if (c.thr_wr)
      next_cnt = c.thr_next;
    else if (c.tick)
    begin
      case (c.mode)
        fti_pkg::FTI_INJ_PERIODIC:
          next_cnt = hit ? c.thr_next : c.cnt - 8'h01;
        fti_pkg::FTI_INJ_ONESHOT:
          if (state == fti_pkg::FTI_OS_WAIT && c.jk && !os_fire_jk)
          begin
            next_cnt   = c.thr_next;
            next_state = fti_pkg::FTI_OS_RUN;
          end
          else if (state == fti_pkg::FTI_OS_RUN)
          begin
            next_cnt   = hit ? c.thr_next : c.cnt - 8'h01;
            next_state = hit ? fti_pkg::FTI_OS_WAIT : state;
          end
        default:
          next_cnt = c.cnt;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c.cnt <= `FTI_CNT_RESET;
      state <= fti_pkg::FTI_OS_WAIT;
    end
    else
    begin
      c.cnt <= next_cnt;
      state <= next_state;
    end
  end

  cnt_reload_a: assert property (@(posedge mclk) disable iff (!rst_n)
    c.thr_wr |=> c.cnt == $past(c.thr_next))
    else $error("counter did not reload on threshold write");

  cnt_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (c.mode == fti_pkg::FTI_INJ_NONE || c.mode == fti_pkg::FTI_INJ_CONT)
    && !c.thr_wr |=> $stable(c.cnt))
    else $error("counter moved outside one-shot or periodic");

  zero_jk_a: assert property (@(posedge mclk) disable iff (!rst_n)
    c.tick && oneshot && state == fti_pkg::FTI_OS_WAIT && c.jk
    && c.thr_next == 8'h00 |-> c.inject && c.os_done)
    else $error("delimiter pair not replaced at zero threshold");

  periodic_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
    c.tick && periodic && c.thr_next == 8'h00 && c.cnt == 8'h00
    |-> c.inject ##1 c.cnt == 8'h00)
    else $error("zero threshold periodic missed a pair");

  oneshot_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
    c.tick && !c.thr_wr && oneshot && state == fti_pkg::FTI_OS_RUN
    && c.cnt > 8'h01 |-> !c.inject ##1 c.cnt == $past(c.cnt) - 8'h01)
    else $error("one-shot injected early or failed to count");

endmodule
`default_nettype wire

// ===== rtl/fti_tx_inject.sv
// transmit state control register and symbol pair injection path
// What this block does
// - Bits 4:3 of transmit_state_control pick one of four injection modes.
// - Active injection overrides smoother, repeat filter, encoder, tx modes.
// - With no injection and tx mode active, request data passes through untouched.
// - One-shot replaces the pair n pairs after a JK delimiter.
// - One-shot with zero threshold replaces the JK pair itself.
// - Hardware clears only the low injection bit after a one-shot.
// - Periodic replaces every n-th pair; zero threshold replaces every pair.
// - Periodic injection is not realigned to JK boundaries.
// - Continuous replaces every pair, whatever the threshold.
// - Started counter keeps counting; only a threshold write affects it.
// - Bit 5 turns the smoother on when set, off when clear.
// - Bit 6 turns request data parity checking on when set.
// - Reserved bit 7 resets to one and takes any write harmlessly.
// - Codes 00 none, 01 one-shot, 10 periodic, 11 continuous.
// - 8-bit down-counter, one step per 80 ns, reloads at one or zero and on write.
// - Reset gives tx mode off, smoother on, bit 7 set, rest clear.
`default_nettype none
`include "fti_consts.svh"
module fti_tx_inject (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            pair_req,
  input  wire logic [9:0] pair_in,
  input  wire logic       pair_par,
  output logic      [9:0] tx_pair,
  output logic            tx_enable,
  output logic            tx_injected,
  output logic            parity_err,
  output logic            smoother_on,
  output logic            request_parity_on,
  output logic      [2:0] tx_mode_field,
  output logic      [7:0] inject_count_value
);

  // true when a pair is the J then K starting delimiter
  function automatic logic is_jk(input logic [9:0] p);
    is_jk = p[9:5] == `FTI_SYM_J && p[4:0] == `FTI_SYM_K;
  endfunction

  // reset release through two flops so release is clean to mclk
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  // register storage
  logic [7:0]             transmit_state_control;
  logic [7:0]             inject_threshold;
  logic [4:0]             inject_symbol_a;
  logic [4:0]             inject_symbol_b;
  logic [7:0]             next_tsc;
  logic [7:0]             next_thr;
  logic [7:0]             next_rdata;
  logic                   wr_tsc;
  logic                   wr_thr;
  logic                   wr_syma;
  logic                   wr_symb;
  fti_pkg::fti_inj_mode_t inj_mode;
  fti_pkg::fti_tx_mode_t  tm;

  // address decode for writes
  assign wr_tsc  = reg_wr && reg_addr == `FTI_ADDR_TSC;
  assign wr_thr  = reg_wr && reg_addr == `FTI_ADDR_THR;
  assign wr_syma = reg_wr && reg_addr == `FTI_ADDR_SYMA;
  assign wr_symb = reg_wr && reg_addr == `FTI_ADDR_SYMB;

  // field views of transmit_state_control
  assign inj_mode = fti_pkg::fti_inj_mode_t'(
    transmit_state_control[`FTI_IC_HI_BIT:`FTI_IC_LO_BIT]);
  assign tm = fti_pkg::fti_tx_mode_t'(
    transmit_state_control[`FTI_TM_MSB:`FTI_TM_LSB]);
  assign smoother_on       = transmit_state_control[`FTI_SMOOTH_BIT];
  assign request_parity_on = transmit_state_control[`FTI_PARITY_BIT];
  assign tx_mode_field     = transmit_state_control[`FTI_TM_MSB:`FTI_TM_LSB];

  fti_cnt_if cnt_if ();

  // a software write in the same cycle as the one-shot clear wins,
  // so a freshly armed mode is never lost to a stale acknowledgement
  assign next_tsc = wr_tsc ? reg_wdata
                  : cnt_if.os_done
                    ? (transmit_state_control & ~`FTI_IC_LO_MASK)
                    : transmit_state_control;
  assign next_thr = wr_thr ? reg_wdata : inject_threshold;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      transmit_state_control <= `FTI_TSC_RESET;
      inject_threshold       <= `FTI_THR_RESET;
      inject_symbol_a        <= `FTI_SYM_RESET;
      inject_symbol_b        <= `FTI_SYM_RESET;
    end
    else
    begin
      transmit_state_control <= next_tsc;
      inject_threshold       <= next_thr;
      if (wr_syma)
        inject_symbol_a <= reg_wdata[4:0];
      if (wr_symb)
        inject_symbol_b <= reg_wdata[4:0];
    end
  end

  // read mux; unmapped addresses and reserved symbol bits read zero
  assign next_rdata =
      reg_addr == `FTI_ADDR_TSC  ? transmit_state_control
    : reg_addr == `FTI_ADDR_THR  ? inject_threshold
    : reg_addr == `FTI_ADDR_SYMA ? {3'h0, inject_symbol_a}
    : reg_addr == `FTI_ADDR_SYMB ? {3'h0, inject_symbol_b}
    : 8'h00;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // pair rate divider: one enable every 80 ns
  localparam logic [1:0] PAIR_LAST = 2'(`FTI_PAIR_CYC - 1);
  logic [1:0] div;
  logic       tick;

  assign tick     = div == PAIR_LAST;
  assign pair_req = tick;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      div <= 2'h0;
    else
      div <= tick ? 2'h0 : div + 2'h1;
  end

  // counter hookup; it sees the threshold as it will be after a write
  assign cnt_if.tick     = tick;
  assign cnt_if.jk       = is_jk(pair_in);
  assign cnt_if.mode     = inj_mode;
  assign cnt_if.thr_next = next_thr;
  assign cnt_if.thr_wr   = wr_thr;
  assign inject_count_value = cnt_if.cnt;

  fti_inj_counter u_cnt (
    .mclk  (mclk),
    .rst_n (rst_n),
    .c     (cnt_if.cnt_side)
  );

  logic [9:0] mode_pair;
  logic       mode_txe;

  fti_tx_mode_gen u_mode (
    .tm   (tm),
    .pair (mode_pair),
    .txe  (mode_txe)
  );

  // output selection: injection first, then tx mode, then request data
  logic       use_inj;
  logic [9:0] inj_pair;
  logic [9:0] next_tx;
  logic       next_perr;

  assign inj_pair = {inject_symbol_a, inject_symbol_b};
  assign use_inj  = inj_mode == fti_pkg::FTI_INJ_CONT
                 || cnt_if.inject;
  assign next_tx  = use_inj ? inj_pair
                  : tm == fti_pkg::FTI_TM_ACTIVE ? pair_in
                  : mode_pair;
  // odd parity over the pair; a bad pair is still passed on
  assign next_perr = tick && request_parity_on
                  && !(^{pair_in, pair_par});

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_pair     <= `FTI_PAIR_RESET;
      tx_enable   <= 1'b0;
      tx_injected <= 1'b0;
    end
    else if (tick)
    begin
      tx_pair     <= next_tx;
      tx_enable   <= mode_txe || use_inj;
      tx_injected <= use_inj;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      parity_err <= 1'b0;
    else
      parity_err <= next_perr;
  end

  ic_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_tsc |=> inj_mode == $past(reg_wdata[4:3]))
    else $error("injection mode not taken from bits 4:3");

  inject_prio_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && use_inj |=> tx_pair == $past(inj_pair) && tx_injected)
    else $error("injected pair lost to another source");

  pass_thru_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && inj_mode == fti_pkg::FTI_INJ_NONE
    && tm == fti_pkg::FTI_TM_ACTIVE |=> tx_pair == $past(pair_in)
    && !tx_injected)
    else $error("request data altered with no injection");

  cont_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && inj_mode == fti_pkg::FTI_INJ_CONT |=> tx_injected)
    else $error("continuous mode skipped a pair");

  oneshot_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_if.os_done && !wr_tsc |=> !transmit_state_control[3]
    && transmit_state_control[7:4] == $past(transmit_state_control[7:4])
    && transmit_state_control[2:0] == $past(transmit_state_control[2:0]))
    else $error("one-shot acknowledge touched the wrong bits");

  hold_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_tsc && !cnt_if.os_done |=> $stable(transmit_state_control))
    else $error("control register changed without a write");

  smooth_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_tsc |=> smoother_on == $past(reg_wdata[5]))
    else $error("smoother enable did not follow bit 5");

  parity_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !request_parity_on |=> !parity_err)
    else $error("parity error flagged while checking is off");

  rsvd_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_tsc |=> transmit_state_control[7] == $past(reg_wdata[7]))
    else $error("reserved bit did not take the written value");

  tick_rate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick |=> !tick [*3] ##1 tick)
    else $error("pair enable not every four clocks");

  reset_val_a: assert property (@(posedge mclk)
    $rose(rst_n) |-> transmit_state_control == 8'ha2)
    else $error("control register wrong after reset");

  // per-pair outputs and bus read back, checked from the port side
  inj_enable_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && use_inj
    |=> tx_enable)
    else $error("injected pair sent with the driver off");

  off_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && !use_inj && tm == fti_pkg::FTI_TM_OFF
    |=> !tx_enable && tx_pair == 10'h000)
    else $error("off mode drove the line without injection");

  none_clean_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && inj_mode == fti_pkg::FTI_INJ_NONE
    |=> !tx_injected)
    else $error("pair marked injected with injection off");

  sym_inject_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && cnt_if.inject
    |=> tx_pair == $past(inj_pair))
    else $error("counted injection sent the wrong symbols");

  sym_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `FTI_ADDR_SYMA
    |=> reg_rdata == {3'h0, $past(inject_symbol_a)})
    else $error("first injection symbol read back wrong");

  os_return_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_if.os_done && !wr_tsc
    |=> inj_mode == fti_pkg::FTI_INJ_NONE)
    else $error("one-shot did not return to normal transmission");

  no_realign_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && inj_mode == fti_pkg::FTI_INJ_PERIODIC && cnt_if.jk && !wr_thr
    && cnt_if.cnt > 8'h01
    |=> cnt_if.cnt == $past(cnt_if.cnt) - 8'h01)
    else $error("periodic count realigned to a delimiter");

  parity_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && request_parity_on && !(^{pair_in, pair_par})
    |=> parity_err)
    else $error("bad request parity not flagged");

  rdata_ctl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `FTI_ADDR_TSC
    |=> reg_rdata == $past(transmit_state_control))
    else $error("control register read back wrong");

  thr_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_thr
    |=> inject_threshold == $past(reg_wdata))
    else $error("threshold write not stored");

  tx_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !tick
    |=> $stable(tx_pair) && $stable(tx_injected))
    else $error("transmit pair changed between pair enables");

endmodule
`default_nettype wire

// ===== testbench/fti_mac_model.sv
// request data source standing in for the upstream mac
`default_nettype none
`include "fti_consts.svh"
module fti_mac_model (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       pair_req,
  input  wire logic       send_jk,
  input  wire logic       bad_par,
  output logic      [9:0] pair_in,
  output logic            pair_par
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] seq;

  // data pairs lead with a non-j symbol, so they never look like a delimiter
  assign pair_in  = send_jk ? {`FTI_SYM_J, `FTI_SYM_K} : {5'h0a, seq};
  // odd parity; bad_par spoils it only when the bench asks
  assign pair_par = ~(^pair_in) ^ bad_par;

  // a fresh data pair once the current one has been taken
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      seq <= 5'h00;
    else if (pair_req)
      seq <= seq + 5'h01;
  end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the transmit symbol injection block
`default_nettype none
`include "fti_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] ctl;
    logic       thru;
    logic [9:0] pat;
    logic       txe;
  } fti_row_t;

  logic       mclk;
  logic       nrst;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       pair_req;
  logic [9:0] pair_in;
  logic       pair_par;
  logic [9:0] tx_pair;
  logic       tx_enable;
  logic       tx_injected;
  logic       parity_err;
  logic       smoother_on;
  logic       request_parity_on;
  logic [2:0] tx_mode_field;
  logic [7:0] inject_count_value;
  logic       send_jk;
  logic       bad_par;
  logic [9:0] symp;
  logic [9:0] sent;
  logic [7:0] cur_ctl;
  logic [7:0] thr_list [3] = '{8'h00, 8'h01, 8'h03};
  int         bad_count = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  int         c;
  fti_row_t   rows [12];

  fti_tx_inject u_fti_tx_inject (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pair_req(pair_req), .pair_in(pair_in), .pair_par(pair_par),
    .tx_pair(tx_pair), .tx_enable(tx_enable), .tx_injected(tx_injected),
    .parity_err(parity_err), .smoother_on(smoother_on),
    .request_parity_on(request_parity_on), .tx_mode_field(tx_mode_field),
    .inject_count_value(inject_count_value)
  );

  fti_mac_model u_fti_mac_model (
    .mclk(mclk), .nrst(nrst), .pair_req(pair_req), .send_jk(send_jk),
    .bad_par(bad_par), .pair_in(pair_in), .pair_par(pair_par)
  );

  always #10 mclk = ~mclk;

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobe lowered one edge after raising, so calls never collide
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    if (a == `FTI_ADDR_TSC)
      cur_ctl = d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({2'b00, reg_rdata}, {2'b00, exp});
  endtask

  // one pair through the stream; sampled once the take edge has landed
  task automatic step(input logic jk, input logic bad, input logic inj,
                      input logic thru, input logic [9:0] pat,
                      input logic txe);
    int n;
    @(posedge mclk);
    send_jk <= jk;
    bad_par <= bad;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (pair_req !== 1'b1 && n < 16);
    chk({9'h0, pair_req}, 10'h001);
    sent = pair_in;
    @(posedge mclk);
    #1;
    chk(tx_pair, inj ? symp : (thru ? sent : pat));
    chk({9'h0, tx_injected}, {9'h0, inj});
    chk({9'h0, tx_enable}, {9'h0, txe});
    chk({9'h0, parity_err}, {9'h0, bad & cur_ctl[`FTI_PARITY_BIT]});
  endtask

  task automatic do_reset();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    cur_ctl = `FTI_TSC_RESET;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic chk_reset();
    rd(`FTI_ADDR_TSC, 8'ha2);
    rd(`FTI_ADDR_THR, 8'h00);
    rd(`FTI_ADDR_SYMA, 8'h00);
    rd(`FTI_ADDR_SYMB, 8'h00);
    chk({9'h0, smoother_on}, 10'h001);
    chk({9'h0, request_parity_on}, 10'h000);
    chk({7'h0, tx_mode_field}, 10'h002);
    chk({2'h0, inject_count_value}, 10'h000);
  endtask

  initial
  begin
    mclk = 1'b0;
    nrst = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    send_jk = 1'b0;
    bad_par = 1'b0;
    symp = {5'h15, 5'h0c};
    rows = '{'{8'h20, 1'b1, 10'h000, 1'b1}, '{8'h21, 1'b0, 10'h3ff, 1'b1},
             '{8'h22, 1'b0, 10'h000, 1'b0}, '{8'h23, 1'b0, 10'h000, 1'b1},
             '{8'h24, 1'b0, 10'h080, 1'b1}, '{8'h25, 1'b0, 10'h084, 1'b1},
             '{8'h26, 1'b0, 10'h000, 1'b1}, '{8'h27, 1'b0, 10'h000, 1'b1},
             '{8'h00, 1'b1, 10'h000, 1'b1}, '{8'ha0, 1'b1, 10'h000, 1'b1},
             '{8'h60, 1'b1, 10'h000, 1'b1}, '{8'he1, 1'b0, 10'h3ff, 1'b1}};
    do_reset();
    chk_reset();
    $display("test reset done");
    wr(`FTI_ADDR_SYMA, 8'hf5);
    wr(`FTI_ADDR_SYMB, 8'h0c);
    rd(`FTI_ADDR_SYMA, 8'h15);
    wr(5'h1f, 8'h55);
    rd(5'h1f, 8'h00);
    // plain transmit modes with injection off
    foreach (rows[i])
    begin
      wr(`FTI_ADDR_TSC, rows[i].ctl);
      rd(`FTI_ADDR_TSC, rows[i].ctl);
      chk({9'h0, smoother_on}, {9'h0, rows[i].ctl[5]});
      chk({9'h0, request_parity_on}, {9'h0, rows[i].ctl[6]});
      chk({7'h0, tx_mode_field}, {7'h0, rows[i].ctl[2:0]});
      step(1'b0, 1'b0, 1'b0, rows[i].thru, rows[i].pat, rows[i].txe);
    end
    $display("test table done");
    wr(`FTI_ADDR_TSC, 8'h60);
    step(1'b0, 1'b1, 1'b0, 1'b1, 10'h000, 1'b1);
    step(1'b0, 1'b0, 1'b0, 1'b1, 10'h000, 1'b1);
    wr(`FTI_ADDR_TSC, 8'h20);
    step(1'b0, 1'b1, 1'b0, 1'b1, 10'h000, 1'b1);
    $display("test parity done");
    // continuous over tx mode off: injection wins and enables the driver
    wr(`FTI_ADDR_THR, 8'h05);
    wr(`FTI_ADDR_TSC, 8'h1a);
    for (int k = 0; k < 4; k++)
      step(k == 2, 1'b0, 1'b1, 1'b0, 10'h000, 1'b1);
    chk({2'h0, inject_count_value}, 10'h005);
    $display("test continuous done");
    // periodic, with a jk mid-run that must not realign the count
    foreach (thr_list[j])
    begin
      wr(`FTI_ADDR_TSC, 8'h20);
      wr(`FTI_ADDR_THR, thr_list[j]);
      chk({2'h0, inject_count_value}, {2'h0, thr_list[j]});
      wr(`FTI_ADDR_TSC, 8'h30);
      c = int'(thr_list[j]);
      for (int k = 0; k < 8; k++)
      begin
        step(k == 4, 1'b0, c <= 1, 1'b1, 10'h000, 1'b1);
        c = (c <= 1) ? int'(thr_list[j]) : c - 1;
        chk({2'h0, inject_count_value}, 10'(c));
      end
    end
    $display("test periodic done");
    // one-shot, other bits set to prove only the low control bit clears
    wr(`FTI_ADDR_TSC, 8'h20);
    wr(`FTI_ADDR_THR, 8'h02);
    wr(`FTI_ADDR_TSC, 8'he8);
    step(1'b0, 1'b0, 1'b0, 1'b1, 10'h000, 1'b1);
    step(1'b1, 1'b0, 1'b0, 1'b1, 10'h000, 1'b1);
    step(1'b0, 1'b0, 1'b0, 1'b1, 10'h000, 1'b1);
    step(1'b0, 1'b0, 1'b1, 1'b1, 10'h000, 1'b1);
    rd(`FTI_ADDR_TSC, 8'he0);
    step(1'b1, 1'b0, 1'b0, 1'b1, 10'h000, 1'b1);
    step(1'b0, 1'b0, 1'b0, 1'b1, 10'h000, 1'b1);
    wr(`FTI_ADDR_THR, 8'h00);
    wr(`FTI_ADDR_TSC, 8'h28);
    step(1'b1, 1'b0, 1'b1, 1'b1, 10'h000, 1'b1);
    rd(`FTI_ADDR_TSC, 8'h20);
    $display("test one shot done");
    // second reset in mid-run returns to defaults
    wr(`FTI_ADDR_TSC, 8'h5b);
    do_reset();
    chk_reset();
    step(1'b0, 1'b0, 1'b0, 1'b0, 10'h000, 1'b0);
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
